// ===== logic/smsr_regs.svh
/*
  Constants of the sideband status reporting block: commands, opcodes,
  field positions and timing. Assumes inclusion by bare name.
*/
// Summary of operation
// - Bit 0 flags port 0x026F, bit 1 flags port 0x0298.
// - Bits 2, 3, 4 flag broadcast, neighbor discovery and ARP packets.
// - Bit 11 flags a VLAN filter hit; bits 10:8 stay zero.
// - Bits 14:12 give unicast address index, bit 15 any unicast hit.
// - Bit 23 flags a port filter hit, bits 22:16 its number.
// - Bit 27 flags flexible filter hit, bits 26:24 its index.
// - Bit 30 flags an IP address filter hit, bits 29:28 its number.
// - Bit 31 tells IPv4 from IPv6 under bit 30 or 4; 39:32 decision hits.
// - Raise notification on status request or byte-1 change with send-on-change.
// - Command 0xDE always answers opcode 0xDD with current status.
// - Drop the alert when no status read completes within the configured notification timeout.
// - Byte 1 bit 6 set after a command abort since last read.
// - Byte 1 bit 3 set after defaults reload since last read.
// - Byte 1 bits 1:0 power state; single-address reports higher ranked function.
// - Byte 2 bit 3 reads set while any function driver is alive.
// - Byte 2 bit 2 follows OR of function interrupt lines.
// - Byte 2 bit 1 set after any interrupt cause read since last read.
// - Match word sits in long packet status bits 127:88.
// - 0xC0/0xD0 with nothing pending answers status instead of not-acknowledging.
`ifndef SMSR_REGS_SVH
`define SMSR_REGS_SVH
`define SMSR_CMD_STATUS 8'hDE
`define SMSR_CMD_LEG0 8'hC0
`define SMSR_CMD_LEG1 8'hD0
`define SMSR_OP_STATUS 8'hDD
`define SMSR_RESP_COUNT 8'h03
`define SMSR_RESP_LAST 2'h3
`define SMSR_PORT_RMCP0 16'h026F
`define SMSR_PORT_RMCP1 16'h0298
`define SMSR_MS_RMCP0 0
`define SMSR_MS_RMCP1 1
`define SMSR_MS_BCAST 2
`define SMSR_MS_NEIGH 3
`define SMSR_MS_ARP 4
`define SMSR_MS_VLAN 11
`define SMSR_MS_UC_IDX 14:12
`define SMSR_MS_UC 15
`define SMSR_MS_L4_IDX 22:16
`define SMSR_MS_L4 23
`define SMSR_MS_FL_IDX 26:24
`define SMSR_MS_FL 27
`define SMSR_MS_IP_IDX 29:28
`define SMSR_MS_IP 30
`define SMSR_MS_IPV 31
`define SMSR_MS_DEC 39:32
`define SMSR_B1_ABORT 6
`define SMSR_B1_LINK 5
`define SMSR_B1_RELOAD 3
`define SMSR_B1_PWR 1:0
`define SMSR_B2_DRV 3
`define SMSR_B2_INT 2
`define SMSR_B2_ICR 1
`define SMSR_BYTE_RST 8'h00
`define SMSR_MS_RST 40'h0000000000
`define SMSR_LO_RST 88'h0
`define SMSR_CLK_NS 50
`define SMSR_TO_UNIT_NS 1000
`endif

// ===== logic/smsr_pkg.sv
/*
  Types of the sideband status reporting block.
  Assumes smsr_regs.svh supplies the constants.
*/
package smsr_pkg;
  typedef enum logic [1:0] {
    PWR_RESET = 2'b00,
    PWR_UNINIT = 2'b01,
    PWR_ACTIVE = 2'b10,
    PWR_SLEEP = 2'b11
  } smsr_pwr_e;
  typedef enum logic [1:0] {
    LNK_IDLE = 2'b00,
    LNK_WAIT = 2'b01,
    LNK_SEND = 2'b10
  } smsr_lnk_e;
endpackage : smsr_pkg

// ===== logic/smsr_top.sv
/*
  Sideband status reporting: encodes the manageability match word into
  the long packet status, keeps the read-status bytes, raises the alert
  and serves the read-status block read on the link clock.
  Assumes the link side delivers decoded block-read commands and byte
  read strobes on I_SMB_CLK, and that core event inputs are one-cycle
  pulses on I_REF_CLK.
*/
`timescale 1ns/10ps
`include "smsr_regs.svh"
module smsr_top
  import smsr_pkg::*;
#(
  parameter int TICK_CYCLES = `SMSR_TO_UNIT_NS / `SMSR_CLK_NS
)
(
  input wire logic I_REF_CLK, // Core clock, 20 MHz
  input wire logic I_RST, // Async reset, high
  input wire logic I_MATCH_VALID, // Packet filter results valid
  input wire logic [87:0] I_PKT_STATUS_LO, // Low long status bits
  input wire logic I_PORT_VALID, // Packet carries UDP/TCP port
  input wire logic [15:0] I_L4_PORT, // UDP/TCP port
  input wire logic I_BCAST, // Broadcast packet
  input wire logic I_NEIGHBOR, // Neighbor discovery packet
  input wire logic I_ARP, // ARP request or response
  input wire logic I_VLAN_HIT, // VLAN filter hit
  input wire logic I_UC_HIT, // Unicast address hit
  input wire logic [1:0] I_UC_IDX, // Unicast address index
  input wire logic I_L4F_HIT, // Port filter hit
  input wire logic [6:0] I_L4F_IDX, // Port filter number
  input wire logic I_FLEX_HIT, // Flexible filter hit
  input wire logic [2:0] I_FLEX_IDX, // Flexible filter index
  input wire logic I_IP_HIT, // IP address filter hit
  input wire logic [1:0] I_IP_IDX, // IP filter number
  input wire logic I_IP_IS_V6, // Hit was IPv6
  input wire logic [7:0] I_DEC_HIT, // Decision filter hits
  input wire logic I_SIDEBAND_EN, // Sideband reception enabled
  output logic [127:0] O_PKT_STATUS, // Long packet status
  output logic O_PKT_STATUS_VLD, // Long status strobe
  input wire logic I_LINK_UP, // Link up level
  input wire logic I_SINGLE_ADDR, // Single-address mode
  input wire logic [1:0] I_PWR_F0, // Function 0 power state
  input wire logic [1:0] I_PWR_F1, // Function 1 power state
  input wire logic I_CMD_ABORT, // Command abort event
  input wire logic I_NVM_RELOAD, // Defaults reload event
  input wire logic [1:0] I_DRV_SET, // Driver valid set per function
  input wire logic [1:0] I_DRV_LOWPWR, // Driver entered low power
  input wire logic I_PCI_RST, // PCI reset pulse
  input wire logic [1:0] I_INT_LINE, // Function interrupt lines
  input wire logic [1:0] I_ICR_READ, // Interrupt cause read pulses
  input wire logic I_SEND_ON_CHANGE, // Alert on byte-1 change
  input wire logic [7:0] I_NOTIFY_TIMEOUT, // Timeout in units, 0 = none
  input wire logic I_PAYLOAD_PENDING, // Other payload waiting
  input wire logic I_STATUS_REQ_PIN, // Status request pin, async
  output logic O_ALERT_OUT, // Alert pin drive level
  output logic O_ALERT_OE, // Alert pin enable
  output logic O_NOTIFY_TIMEOUT, // Alert dropped by timeout
  output logic [7:0] O_STATUS_B1, // Current status byte 1
  output logic [7:0] O_STATUS_B2, // Current status byte 2
  input wire logic I_SMB_CLK, // Link clock
  input wire logic I_SMB_CMD_STB, // Block-read command taken
  input wire logic [7:0] I_SMB_CMD, // Block-read command code
  input wire logic I_SMB_BYTE_RD, // Next byte wanted
  output logic O_SMB_RESP_RDY, // Response staged
  output logic [7:0] O_SMB_RD_DATA // Byte last read
);

  logic [39:0] mng_ff;
  logic [87:0] lo_ff;
  logic vld_ff;
  logic [39:0] nxt_mng;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b1_prev_ff;
  logic abort_ff;
  logic reload_ff;
  logic icr_ff;
  logic [1:0] drv_ff;
  logic [1:0] pwr_rep;
  logic rq_s1_ff, rq_s2_ff, rq_s3_ff;
  logic lreq_s1_ff, lreq_s2_ff, lreq_s3_ff;
  logic ldone_s1_ff, ldone_s2_ff, ldone_s3_ff;
  logic ack_tgl_ff;
  logic [7:0] snap_b1_ff, snap_b2_ff;
  logic req_evt, done_evt, status_req_evt, change_evt;
  logic alert_ff;
  logic to_ff;
  logic [15:0] tick_ff;
  logic [7:0] unit_ff;
  logic to_hit;
  smsr_lnk_e lst_ff;
  logic req_tgl_ff, done_tgl_ff;
  logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
  logic pend_s1_ff, pend_s2_ff;
  logic [7:0] l_b1_ff, l_b2_ff;
  logic [1:0] idx_ff;
  logic [7:0] rd_ff;
  logic is_status_cmd;

  function automatic logic [1:0] smsr_rank(input logic [1:0] p);
    unique case (smsr_pwr_e'(p))
      PWR_ACTIVE: smsr_rank = 2'h3;
      PWR_UNINIT: smsr_rank = 2'h2;
      PWR_RESET: smsr_rank = 2'h1;
      PWR_SLEEP: smsr_rank = 2'h0;
    endcase
  endfunction : smsr_rank

  // Match word; indices forced to zero when their hit flag is clear
  always_comb
  begin
    nxt_mng = `SMSR_MS_RST;
    nxt_mng[`SMSR_MS_RMCP0] = I_PORT_VALID && (I_L4_PORT == `SMSR_PORT_RMCP0);
    nxt_mng[`SMSR_MS_RMCP1] = I_PORT_VALID && (I_L4_PORT == `SMSR_PORT_RMCP1);
    nxt_mng[`SMSR_MS_BCAST] = I_BCAST;
    nxt_mng[`SMSR_MS_NEIGH] = I_NEIGHBOR;
    nxt_mng[`SMSR_MS_ARP] = I_ARP;
    nxt_mng[`SMSR_MS_VLAN] = I_VLAN_HIT;
    nxt_mng[`SMSR_MS_UC_IDX] = I_UC_HIT ? {1'b0, I_UC_IDX} : 3'h0;
    nxt_mng[`SMSR_MS_UC] = I_UC_HIT;
    nxt_mng[`SMSR_MS_L4_IDX] = I_L4F_HIT ? I_L4F_IDX : 7'h00;
    nxt_mng[`SMSR_MS_L4] = I_L4F_HIT;
    nxt_mng[`SMSR_MS_FL_IDX] = I_FLEX_HIT ? I_FLEX_IDX : 3'h0;
    nxt_mng[`SMSR_MS_FL] = I_FLEX_HIT;
    nxt_mng[`SMSR_MS_IP_IDX] = I_IP_HIT ? I_IP_IDX : 2'h0;
    nxt_mng[`SMSR_MS_IP] = I_IP_HIT;
    nxt_mng[`SMSR_MS_IPV] = I_IP_IS_V6 && (I_IP_HIT || I_ARP);
    nxt_mng[`SMSR_MS_DEC] = I_DEC_HIT;
    // Word zeroed when sideband reception is off, so nothing stale leaks
    if (!I_SIDEBAND_EN)
    begin
      nxt_mng = `SMSR_MS_RST;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      mng_ff <= `SMSR_MS_RST;
      lo_ff <= `SMSR_LO_RST;
    end
    else if (I_MATCH_VALID)
    begin
      mng_ff <= nxt_mng;
      lo_ff <= I_PKT_STATUS_LO;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
      vld_ff <= 1'b0;
    else
      vld_ff <= I_MATCH_VALID;
  end

  assign O_PKT_STATUS = {mng_ff, lo_ff};
  assign O_PKT_STATUS_VLD = vld_ff;

  // Status bytes
  always_comb
  begin
    pwr_rep = I_PWR_F0;
    if (I_SINGLE_ADDR && (smsr_rank(I_PWR_F1) > smsr_rank(I_PWR_F0)))
      pwr_rep = I_PWR_F1;
  end

  always_comb
  begin
    b1 = `SMSR_BYTE_RST;
    b1[`SMSR_B1_ABORT] = abort_ff;
    b1[`SMSR_B1_LINK] = I_LINK_UP;
    b1[`SMSR_B1_RELOAD] = reload_ff;
    b1[`SMSR_B1_PWR] = pwr_rep;
    b2 = `SMSR_BYTE_RST;
    b2[`SMSR_B2_DRV] = |drv_ff;
    b2[`SMSR_B2_INT] = |I_INT_LINE;
    b2[`SMSR_B2_ICR] = icr_ff;
  end

  assign O_STATUS_B1 = b1;
  assign O_STATUS_B2 = b2;

  // Sticky flags: a new event beats the clear of a delivered response
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      abort_ff <= 1'b0;
      reload_ff <= 1'b0;
      icr_ff <= 1'b0;
    end
    else
    begin
      abort_ff <= (abort_ff && !(done_evt && snap_b1_ff[`SMSR_B1_ABORT])) || I_CMD_ABORT;
      reload_ff <= (reload_ff && !(done_evt && snap_b1_ff[`SMSR_B1_RELOAD]))
        || I_NVM_RELOAD;
      icr_ff <= (icr_ff && !(done_evt && snap_b2_ff[`SMSR_B2_ICR])) || (|I_ICR_READ);
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
      drv_ff <= 2'b00;
    else
      for (int f = 0; f < 2; f++)
        drv_ff[f] <= I_DRV_SET[f] || (drv_ff[f] && !I_DRV_LOWPWR[f] && !I_PCI_RST);
  end

  // Crossings into the core domain
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      rq_s1_ff <= 1'b0;
      rq_s2_ff <= 1'b0;
      rq_s3_ff <= 1'b0;
      lreq_s1_ff <= 1'b0;
      lreq_s2_ff <= 1'b0;
      lreq_s3_ff <= 1'b0;
      ldone_s1_ff <= 1'b0;
      ldone_s2_ff <= 1'b0;
      ldone_s3_ff <= 1'b0;
    end
    else
    begin
      rq_s1_ff <= I_STATUS_REQ_PIN;
      rq_s2_ff <= rq_s1_ff;
      rq_s3_ff <= rq_s2_ff;
      lreq_s1_ff <= req_tgl_ff;
      lreq_s2_ff <= lreq_s1_ff;
      lreq_s3_ff <= lreq_s2_ff;
      ldone_s1_ff <= done_tgl_ff;
      ldone_s2_ff <= ldone_s1_ff;
      ldone_s3_ff <= ldone_s2_ff;
    end
  end

  assign status_req_evt = rq_s2_ff && !rq_s3_ff;
  assign req_evt = lreq_s2_ff ^ lreq_s3_ff;
  assign done_evt = ldone_s2_ff ^ ldone_s3_ff;
  assign change_evt = I_SEND_ON_CHANGE && (b1 != b1_prev_ff);

  // Snapshot held until the next request, so the link reads it steady
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      snap_b1_ff <= `SMSR_BYTE_RST;
      snap_b2_ff <= `SMSR_BYTE_RST;
      ack_tgl_ff <= 1'b0;
    end
    else if (req_evt)
    begin
      snap_b1_ff <= b1;
      snap_b2_ff <= b2;
      ack_tgl_ff <= !ack_tgl_ff;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
      b1_prev_ff <= `SMSR_BYTE_RST;
    else
      b1_prev_ff <= b1;
  end

  // Alert: raised by request or change, dropped on delivery or timeout
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
      alert_ff <= 1'b0;
    else if (status_req_evt || change_evt)
      alert_ff <= 1'b1;
    else if (done_evt || to_hit)
      alert_ff <= 1'b0;
  end

  assign to_hit = alert_ff && (I_NOTIFY_TIMEOUT != 8'h00) && (unit_ff == I_NOTIFY_TIMEOUT);

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      tick_ff <= 16'h0000;
      unit_ff <= 8'h00;
    end
    else if (!alert_ff || status_req_evt || change_evt)
    begin
      tick_ff <= 16'h0000;
      unit_ff <= 8'h00;
    end
    else if (tick_ff == 16'(TICK_CYCLES - 1))
    begin
      tick_ff <= 16'h0000;
      unit_ff <= unit_ff + 8'h01;
    end
    else
      tick_ff <= tick_ff + 16'h0001;
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
      to_ff <= 1'b0;
    else
      to_ff <= to_hit && !(status_req_evt || change_evt);
  end

  assign O_NOTIFY_TIMEOUT = to_ff;
  assign O_ALERT_OUT = 1'b0;
  assign O_ALERT_OE = alert_ff;

  // Link domain
  assign is_status_cmd = (I_SMB_CMD == `SMSR_CMD_STATUS) ||
    (((I_SMB_CMD == `SMSR_CMD_LEG0) || (I_SMB_CMD == `SMSR_CMD_LEG1)) && !pend_s2_ff);

  always_ff @(posedge I_SMB_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
      pend_s1_ff <= 1'b0;
      pend_s2_ff <= 1'b0;
    end
    else
    begin
      ack_s1_ff <= ack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
      pend_s1_ff <= I_PAYLOAD_PENDING;
      pend_s2_ff <= pend_s1_ff;
    end
  end

  always_ff @(posedge I_SMB_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      lst_ff <= LNK_IDLE;
      req_tgl_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
      idx_ff <= 2'h0;
      l_b1_ff <= `SMSR_BYTE_RST;
      l_b2_ff <= `SMSR_BYTE_RST;
    end
    else
    begin
      unique case (lst_ff)
        LNK_IDLE:
        begin
          if (I_SMB_CMD_STB && is_status_cmd)
          begin
            req_tgl_ff <= !req_tgl_ff;
            lst_ff <= LNK_WAIT;
          end
        end
        LNK_WAIT:
        begin
          if (ack_s2_ff ^ ack_s3_ff)
          begin
            l_b1_ff <= snap_b1_ff;
            l_b2_ff <= snap_b2_ff;
            idx_ff <= 2'h0;
            lst_ff <= LNK_SEND;
          end
        end
        LNK_SEND:
        begin
          if (I_SMB_BYTE_RD)
          begin
            idx_ff <= idx_ff + 2'h1;
            if (idx_ff == `SMSR_RESP_LAST)
            begin
              done_tgl_ff <= !done_tgl_ff;
              lst_ff <= LNK_IDLE;
            end
          end
        end
        default: lst_ff <= LNK_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_SMB_CLK or posedge I_RST)
  begin
    if (I_RST)
      rd_ff <= `SMSR_BYTE_RST;
    else if (lst_ff == LNK_SEND && I_SMB_BYTE_RD)
    begin
      unique case (idx_ff)
        2'h0: rd_ff <= `SMSR_RESP_COUNT;
        2'h1: rd_ff <= `SMSR_OP_STATUS;
        2'h2: rd_ff <= l_b1_ff;
        2'h3: rd_ff <= l_b2_ff;
      endcase
    end
  end

  assign O_SMB_RESP_RDY = (lst_ff == LNK_SEND);
  assign O_SMB_RD_DATA = rd_ff;

  // Checks
  property p_rmcp0;
    @(posedge I_REF_CLK) disable iff (I_RST)
      I_MATCH_VALID && I_SIDEBAND_EN && I_PORT_VALID && (I_L4_PORT == `SMSR_PORT_RMCP0)
      |=> mng_ff[`SMSR_MS_RMCP0] && !mng_ff[`SMSR_MS_RMCP1];
  endproperty
  a_rmcp0: assert property (p_rmcp0) else $error("port 0x026F not flagged");

  property p_flex_idx;
    @(posedge I_REF_CLK) disable iff (I_RST)
      I_MATCH_VALID && !I_FLEX_HIT |=> !mng_ff[`SMSR_MS_FL] && (mng_ff[`SMSR_MS_FL_IDX] == 3'h0);
  endproperty
  a_flex_idx: assert property (p_flex_idx) else $error("flex index without hit");

  property p_ipv;
    @(posedge I_REF_CLK) disable iff (I_RST)
      I_MATCH_VALID && I_SIDEBAND_EN |=>
      mng_ff[`SMSR_MS_IPV] == $past(I_IP_IS_V6 && (I_IP_HIT || I_ARP));
  endproperty
  a_ipv: assert property (p_ipv) else $error("ip version bit wrong");

  property p_uc;
    @(posedge I_REF_CLK) disable iff (I_RST)
      I_MATCH_VALID && I_SIDEBAND_EN |=> mng_ff[`SMSR_MS_UC] == $past(I_UC_HIT);
  endproperty
  a_uc: assert property (p_uc) else $error("unicast hit bit wrong");

  property p_pwr;
    @(posedge I_REF_CLK) disable iff (I_RST)
      I_SINGLE_ADDR && (I_PWR_F1 == PWR_ACTIVE) |-> b1[`SMSR_B1_PWR] == PWR_ACTIVE;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power rank wrong");

  property p_set_wins;
    @(posedge I_REF_CLK) disable iff (I_RST)
      I_CMD_ABORT |=> abort_ff;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("abort event lost");

  property p_alert;
    @(posedge I_REF_CLK) disable iff (I_RST)
      $rose(rq_s2_ff) |=> alert_ff && O_ALERT_OE;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not raised");

  // Snapshot must carry the interrupt level seen when the request arrived
  property p_int;
    @(posedge I_REF_CLK) disable iff (I_RST)
      req_evt |=> snap_b2_ff[`SMSR_B2_INT] == $past(|I_INT_LINE);
  endproperty
  a_int: assert property (p_int) else $error("interrupt pending wrong");

  sequence s_cmd;
    (lst_ff == LNK_IDLE) && I_SMB_CMD_STB && (I_SMB_CMD == `SMSR_CMD_STATUS);
  endsequence
  sequence s_ack;
    (lst_ff == LNK_WAIT) ##[1:11] (lst_ff == LNK_SEND);
  endsequence
  property p_answer;
    @(posedge I_SMB_CLK) disable iff (I_RST)
      s_cmd |=> s_ack;
  endproperty
  a_answer: assert property (p_answer) else $error("status answer not staged");

  property p_header;
    @(posedge I_SMB_CLK) disable iff (I_RST)
      (lst_ff == LNK_SEND) && I_SMB_BYTE_RD && (idx_ff == 2'h1) |=> rd_ff == `SMSR_OP_STATUS;
  endproperty
  a_header: assert property (p_header) else $error("opcode byte wrong");

endmodule : smsr_top

// ===== testbench/smsr_mgr_model.sv
/*
  Management controller model on the link side: issues one block read
  and collects the four response bytes.
  Assumes the link clock runs while a read is under way.
*/
`timescale 1ns/10ps
module smsr_mgr_model
(
  input wire logic i_clk, // Link clock
  input wire logic i_rdy, // Response staged
  input wire logic [7:0] i_data, // Byte last read
  output logic o_stb, // Command strobe
  output logic [7:0] o_cmd, // Command code
  output logic o_rd // Byte read strobe
);
  initial
  begin
    o_stb = 1'b0;
    o_cmd = 8'h00;
    o_rd = 1'b0;
  end
  // Gap 0 holds the strobe up for back-to-back bytes
  task automatic read(input logic [7:0] c, input int gap, output logic ok,
                      output logic [31:0] r);
    int n;
    begin
      r = 32'h0;
      @(negedge i_clk);
      o_stb = 1'b1;
      o_cmd = c;
      @(negedge i_clk);
      o_stb = 1'b0;
      o_cmd = ~c; // Released lines show no stale code
      n = 0;
      while (i_rdy !== 1'b1 && n < 12)
      begin
        @(negedge i_clk);
        n++;
      end
      ok = (i_rdy === 1'b1);
      for (int k = 0; k < 4 && ok; k++)
      begin
        o_rd = 1'b1;
        @(negedge i_clk);
        r = {r[23:0], i_data};
        if (gap > 0 || k == 3)
          o_rd = 1'b0;
        repeat (gap) @(negedge i_clk);
      end
    end
  endtask : read
endmodule : smsr_mgr_model

// ===== testbench/tb_top.sv
/*
  Self-checking bench of the status reporting block.
  Assumes a shortened timeout unit of two core cycles.
*/
`timescale 1ns/10ps
`include "smsr_regs.svh"
module tb_top;
  logic I_REF_CLK = 1'b0, I_RST = 1'b1, I_SMB_CLK = 1'b0, smb_en = 1'b1;
  logic I_MATCH_VALID = 0, I_SIDEBAND_EN = 1, I_LINK_UP = 1, I_SINGLE_ADDR = 0;
  logic I_CMD_ABORT = 0, I_NVM_RELOAD = 0, I_PCI_RST = 0, I_SEND_ON_CHANGE = 0;
  logic I_PAYLOAD_PENDING = 0, I_STATUS_REQ_PIN = 0, ok;
  logic [47:0] flt = 48'h0;
  logic [87:0] lo = {11{8'h5A}};
  logic [1:0] I_PWR_F0 = 2'h2, I_PWR_F1 = 2'h3, I_DRV_SET = 0, I_DRV_LOWPWR = 0;
  logic [1:0] I_INT_LINE = 0, I_ICR_READ = 0;
  logic [7:0] I_NOTIFY_TIMEOUT = 0, O_STATUS_B1, O_STATUS_B2, O_SMB_RD_DATA, cmd;
  logic [127:0] O_PKT_STATUS;
  logic O_PKT_STATUS_VLD, O_ALERT_OUT, O_ALERT_OE, O_NOTIFY_TIMEOUT, O_SMB_RESP_RDY;
  logic cmd_stb, byte_rd;
  logic [31:0] rsp;
  int n_mismatch = 0, num_checks = 0, cyc = 0, n;
  smsr_top #(.TICK_CYCLES(2)) i_dut (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST),
    .I_MATCH_VALID(I_MATCH_VALID), .I_PKT_STATUS_LO(lo), .I_PORT_VALID(flt[47]),
    .I_L4_PORT(flt[46:31]), .I_BCAST(flt[30]), .I_NEIGHBOR(flt[29]), .I_ARP(flt[28]),
    .I_VLAN_HIT(flt[27]), .I_UC_HIT(flt[26]), .I_UC_IDX(flt[25:24]),
    .I_L4F_HIT(flt[23]), .I_L4F_IDX(flt[22:16]), .I_FLEX_HIT(flt[15]),
    .I_FLEX_IDX(flt[14:12]), .I_IP_HIT(flt[11]), .I_IP_IDX(flt[10:9]),
    .I_IP_IS_V6(flt[8]), .I_DEC_HIT(flt[7:0]), .I_SIDEBAND_EN(I_SIDEBAND_EN),
    .O_PKT_STATUS(O_PKT_STATUS), .O_PKT_STATUS_VLD(O_PKT_STATUS_VLD),
    .I_LINK_UP(I_LINK_UP), .I_SINGLE_ADDR(I_SINGLE_ADDR), .I_PWR_F0(I_PWR_F0),
    .I_PWR_F1(I_PWR_F1), .I_CMD_ABORT(I_CMD_ABORT), .I_NVM_RELOAD(I_NVM_RELOAD),
    .I_DRV_SET(I_DRV_SET), .I_DRV_LOWPWR(I_DRV_LOWPWR), .I_PCI_RST(I_PCI_RST),
    .I_INT_LINE(I_INT_LINE), .I_ICR_READ(I_ICR_READ),
    .I_SEND_ON_CHANGE(I_SEND_ON_CHANGE), .I_NOTIFY_TIMEOUT(I_NOTIFY_TIMEOUT),
    .I_PAYLOAD_PENDING(I_PAYLOAD_PENDING), .I_STATUS_REQ_PIN(I_STATUS_REQ_PIN),
    .O_ALERT_OUT(O_ALERT_OUT), .O_ALERT_OE(O_ALERT_OE),
    .O_NOTIFY_TIMEOUT(O_NOTIFY_TIMEOUT), .O_STATUS_B1(O_STATUS_B1),
    .O_STATUS_B2(O_STATUS_B2), .I_SMB_CLK(I_SMB_CLK), .I_SMB_CMD_STB(cmd_stb),
    .I_SMB_CMD(cmd), .I_SMB_BYTE_RD(byte_rd), .O_SMB_RESP_RDY(O_SMB_RESP_RDY),
    .O_SMB_RD_DATA(O_SMB_RD_DATA));
  smsr_mgr_model i_mgr (.i_clk(I_SMB_CLK), .i_rdy(O_SMB_RESP_RDY),
    .i_data(O_SMB_RD_DATA), .o_stb(cmd_stb), .o_cmd(cmd), .o_rd(byte_rd));
  always #25 I_REF_CLK = ~I_REF_CLK;
  // Link clock stops low between frames
  always
  begin
    #40;
    if (smb_en || I_SMB_CLK)
      I_SMB_CLK = ~I_SMB_CLK;
  end
  always @(posedge I_REF_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
    num_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic mtch(input logic [47:0] v, input logic [39:0] e);
    @(negedge I_REF_CLK);
    flt = v;
    I_MATCH_VALID = 1'b1;
    @(negedge I_REF_CLK);
    I_MATCH_VALID = 1'b0;
    n = 0;
    while (O_PKT_STATUS_VLD !== 1'b1 && n < 3)
    begin
      @(negedge I_REF_CLK);
      n++;
    end
    chk("status strobe", 1, O_PKT_STATUS_VLD);
    chk("packet status", {e, lo}, O_PKT_STATUS);
  endtask : mtch
  task automatic rd(input logic [7:0] c, input int gap, input logic eok, input logic [31:0] e);
    smb_en = 1'b1;
    repeat (4) @(posedge I_SMB_CLK);
    i_mgr.read(c, gap, ok, rsp);
    repeat (6) @(posedge I_SMB_CLK);
    smb_en = 1'b0;
    @(negedge I_REF_CLK);
    chk("response ready", eok, ok);
    chk("response", e, rsp);
  endtask : rd
  task automatic drv(input logic [1:0] s, input logic [1:0] l, input logic p, input logic e);
    @(negedge I_REF_CLK);
    {I_DRV_SET, I_DRV_LOWPWR, I_PCI_RST} = {s, l, p};
    @(negedge I_REF_CLK);
    {I_DRV_SET, I_DRV_LOWPWR, I_PCI_RST} = 5'h00;
    @(negedge I_REF_CLK);
    chk("driver valid", e, O_STATUS_B2[3]);
  endtask : drv
  task automatic wt(input logic t, input logic v, input int lim, input string nm);
    n = 0;
    while ((t ? O_NOTIFY_TIMEOUT : O_ALERT_OE) !== v && n < lim)
    begin
      @(negedge I_REF_CLK);
      n++;
    end
    chk(nm, v, t ? O_NOTIFY_TIMEOUT : O_ALERT_OE);
  endtask : wt
  function automatic int rk(input logic [1:0] p);
    return (p == 2'h2) ? 3 : (p == 2'h1) ? 2 : (p == 2'h0) ? 1 : 0;
  endfunction : rk
  initial
  begin
    repeat (6) @(negedge I_REF_CLK);
    I_RST = 1'b0;
    smb_en = 1'b0;
    mtch({1'b1, 16'h026F, 31'h0}, 40'h01);
    mtch({1'b1, 16'h0298, 31'h0}, 40'h02);
    mtch({1'b1, 16'h0270, 31'h0}, 40'h00);
    mtch({17'h0, 3'h7, 28'h0}, 40'h1C);
    mtch({20'h0, 1'b1, 27'h0}, 40'h800);
    mtch({21'h0, 1'b1, 2'h3, 24'h0}, 40'hB000);
    mtch({21'h0, 1'b0, 2'h2, 24'h0}, 40'h0);
    mtch({24'h0, 1'b1, 7'h55, 16'h0}, 40'hD50000);
    mtch({32'h0, 1'b1, 3'h5, 12'h0}, 40'h0D000000);
    mtch({32'h0, 1'b0, 3'h6, 12'h0}, 40'h0);
    mtch({36'h0, 1'b1, 2'h2, 1'b1, 8'h0}, 40'hE0000000);
    mtch({39'h0, 1'b1, 8'h0}, 40'h0);
    mtch({17'h0, 3'h1, 19'h0, 1'b1, 8'h0}, 40'h80000010);
    mtch({40'h0, 8'hA5}, 40'hA500000000);
    I_SIDEBAND_EN = 1'b0;
    mtch({17'h0, 3'h7, 28'h0}, 40'h0);
    $display("test match word done");
    drv(2'h1, 2'h0, 1'b0, 1'b1);
    I_PAYLOAD_PENDING = 1'b1;
    rd(`SMSR_CMD_STATUS, 0, 1, 32'h03DD2208);
    rd(`SMSR_CMD_LEG1, 0, 0, 32'h0);
    I_PAYLOAD_PENDING = 1'b0;
    {I_CMD_ABORT, I_NVM_RELOAD, I_ICR_READ, I_INT_LINE} = 6'h3A;
    @(negedge I_REF_CLK);
    {I_CMD_ABORT, I_NVM_RELOAD, I_ICR_READ} = 4'h0;
    rd(`SMSR_CMD_LEG0, 2, 1, 32'h03DD6A0E);
    rd(`SMSR_CMD_LEG1, 1, 1, 32'h03DD220C);
    I_INT_LINE = 2'h0;
    $display("test status read done");
    I_SINGLE_ADDR = 1'b1;
    for (int a = 0; a < 16; a++)
    begin
      {I_PWR_F0, I_PWR_F1} = a[3:0];
      @(negedge I_REF_CLK);
      chk("power", rk(a[3:2]) >= rk(a[1:0]) ? a[3:2] : a[1:0], O_STATUS_B1[1:0]);
    end
    I_SINGLE_ADDR = 1'b0;
    {I_PWR_F0, I_PWR_F1} = 4'h6;
    @(negedge I_REF_CLK);
    chk("power", 2'h1, O_STATUS_B1[1:0]);
    drv(2'h2, 2'h0, 1'b0, 1'b1);
    drv(2'h0, 2'h1, 1'b0, 1'b1);
    drv(2'h0, 2'h2, 1'b0, 1'b0);
    drv(2'h3, 2'h0, 1'b0, 1'b1);
    drv(2'h0, 2'h0, 1'b1, 1'b0);
    $display("test status bytes done");
    I_STATUS_REQ_PIN = 1'b1;
    wt(1'b0, 1'b1, 8, "alert on request");
    chk("alert level", 0, O_ALERT_OUT);
    rd(`SMSR_CMD_STATUS, 0, 1, 32'h03DD2100);
    wt(1'b0, 1'b0, 20, "alert cleared");
    I_STATUS_REQ_PIN = 1'b0;
    {I_NOTIFY_TIMEOUT, I_SEND_ON_CHANGE} = 9'h005;
    @(negedge I_REF_CLK);
    I_LINK_UP = 1'b0;
    wt(1'b0, 1'b1, 8, "alert on change");
    wt(1'b1, 1'b1, 30, "notify timeout");
    @(negedge I_REF_CLK);
    chk("alert after timeout", 0, O_ALERT_OE);
    $display("test alert done");
    end_of_test();
  end
endmodule : tb_top
